// File: rtl/aps_regs.sv
// flag register and DAC power register of the record path
//
// Contract
// - bits 7 and 3 of the flag register read 1 exactly when applied gain equals programmed gain.
// - bits 6 and 2 show whether the left and right ADC are powered up.
// - bits 5 and 1 read 1 when signal power is below the noise threshold.
// - bits 4 and 0 read 1 when the applied gain equals the channel's maximum allowed gain.
// - all eight flags sit in the read-only register at index 36 and clear to 0 on reset.
// - bit 7 of register 37 is read-write, resets to 0 and powers the left DAC up when 1.
// - bit 6 of register 37 is read-write, resets to 0 and powers the right DAC up when 1.
`timescale 1ns/1ps
`include "aps_consts.svh"

module aps_regs
  import aps_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire aps_chan_s chanLeft,
  input wire aps_chan_s chanRight,
  input wire aps_req_s req,
  output logic [7:0] rdata,
  output logic rdValid,
  output logic leftDacPowerUp,
  output logic rightDacPowerUp,
  output logic [1:0] hpComMode
);

  if (ADDR_W != 8) begin : g_chk
    $error("aps_regs: ADDR_W must be 8");
  end

  aps_state_s state_reg;
  aps_state_s state_next;
  wire logic [7:0] flagsNow;
  aps_chan_s [1:0] chans;
  localparam int CH_STRIDE = `APS_BIT_L_SETTLED - `APS_BIT_R_SETTLED;

  ////////////////////////////////////////////////////////////////////////
  // flag computation

  // index 1 carries the left channel, index 0 the right one
  assign chans = {chanLeft, chanRight};

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    assign flagsNow[`APS_BIT_R_SETTLED + CH_STRIDE * ch] =
      chans[ch].appliedGain == chans[ch].programmedGain;
    assign flagsNow[`APS_BIT_R_ADC_ON + CH_STRIDE * ch] = chans[ch].adcPowered;
    assign flagsNow[`APS_BIT_R_QUIET + CH_STRIDE * ch] = chans[ch].belowNoise;
    assign flagsNow[`APS_BIT_R_SAT + CH_STRIDE * ch] =
      chans[ch].appliedGain == chans[ch].maxGain;
  end

  ////////////////////////////////////////////////////////////////////////
  // register state

  always_comb begin
    state_next = state_reg;
    state_next.rdValid = 1'b0;
    // flags follow converter state only; host data never reaches them
    state_next.flags = flagsNow;
    if (req.wr && req.addr == `APS_OFS_PWR) begin
      // low nibble is reserved and stays zero
      state_next.pwr = req.wdata & `APS_PWR_RW_MASK;
    end
    if (req.rd) begin
      state_next.rdValid = 1'b1;
      case (req.addr)
        `APS_OFS_FLAGS: state_next.rdata = state_reg.flags;
        `APS_OFS_PWR: state_next.rdata = state_reg.pwr;
        default: state_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg.flags <= `APS_FLAGS_RST;
      state_reg.pwr <= `APS_PWR_RST;
      state_reg.rdata <= 8'h00;
      state_reg.rdValid <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata = state_reg.rdata;
  assign rdValid = state_reg.rdValid;
  assign leftDacPowerUp = state_reg.pwr[`APS_BIT_L_DAC];
  assign rightDacPowerUp = state_reg.pwr[`APS_BIT_R_DAC];
  assign hpComMode = state_reg.pwr[`APS_HPCOM_HI:`APS_HPCOM_LO];

  ////////////////////////////////////////////////////////////////////////
  // checks

  a_settled_flag: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 $past(chanLeft.appliedGain != chanLeft.programmedGain)
    |-> !state_reg.flags[`APS_BIT_L_SETTLED] || $past(sys_rst))
    else $error("left settled flag set while gains differ");

  a_settled_right: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst && (chanRight.appliedGain == chanRight.programmedGain)
    |=> state_reg.flags[`APS_BIT_R_SETTLED])
    else $error("right settled flag missing");

  a_adc_power: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst |=> state_reg.flags[`APS_BIT_L_ADC_ON] == $past(chanLeft.adcPowered)
      && state_reg.flags[`APS_BIT_R_ADC_ON] == $past(chanRight.adcPowered))
    else $error("adc power flag does not follow converter");

  a_noise_detect: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst |=> state_reg.flags[`APS_BIT_L_QUIET] == $past(chanLeft.belowNoise)
      && state_reg.flags[`APS_BIT_R_QUIET] == $past(chanRight.belowNoise))
    else $error("signal detection flag wrong");

  a_sat_flag: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst
    |=> state_reg.flags[`APS_BIT_L_SAT] == $past(chanLeft.appliedGain == chanLeft.maxGain)
      && state_reg.flags[`APS_BIT_R_SAT] == $past(chanRight.appliedGain == chanRight.maxGain))
    else $error("saturation flag wrong");

  a_reset_clear: assert property (@(posedge clk)
    sys_rst |=> state_reg.flags == 8'h00 && state_reg.pwr == 8'h00)
    else $error("registers not cleared by reset");

  a_flag_read: assert property (@(posedge clk) disable iff (sys_rst)
    req.rd && req.addr == `APS_OFS_FLAGS |=> rdValid && rdata == $past(state_reg.flags))
    else $error("flag read returns wrong data");

  a_left_dac: assert property (@(posedge clk) disable iff (sys_rst)
    req.wr && req.addr == `APS_OFS_PWR |=> leftDacPowerUp == $past(req.wdata[`APS_BIT_L_DAC]))
    else $error("left dac power bit not written");

  a_right_dac: assert property (@(posedge clk) disable iff (sys_rst)
    req.wr && req.addr == `APS_OFS_PWR |=> rightDacPowerUp == $past(req.wdata[`APS_BIT_R_DAC]))
    else $error("right dac power bit not written");

  a_pwr_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst && !(req.wr && req.addr == `APS_OFS_PWR) |=> $stable(state_reg.pwr))
    else $error("power register changed without a write");

  a_ro_write: assert property (@(posedge clk) disable iff (sys_rst)
    req.wr && req.addr == `APS_OFS_FLAGS |=> state_reg.flags == $past(flagsNow))
    else $error("write reached the flag register");

  ////////////////////////////////////////////////////////////////////////
  // checks: single flag bits

  a_settled_left: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst && chanLeft.appliedGain == chanLeft.programmedGain
    |=> state_reg.flags[`APS_BIT_L_SETTLED])
    else $error("left settled flag missing");

  a_settled_clear: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst && chanRight.appliedGain != chanRight.programmedGain
    |=> !state_reg.flags[`APS_BIT_R_SETTLED])
    else $error("right settled flag set while gains differ");

  a_adc_clear: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst && !chanRight.adcPowered
    |=> !state_reg.flags[`APS_BIT_R_ADC_ON])
    else $error("right adc flag set while converter is down");

  a_quiet_set: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst && chanLeft.belowNoise
    |=> state_reg.flags[`APS_BIT_L_QUIET])
    else $error("left quiet flag missing");

  a_sat_set: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst && chanRight.appliedGain == chanRight.maxGain
    |=> state_reg.flags[`APS_BIT_R_SAT])
    else $error("right saturation flag missing");

  a_sat_clear: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst && chanLeft.appliedGain != chanLeft.maxGain
    |=> !state_reg.flags[`APS_BIT_L_SAT])
    else $error("left saturation flag set below maximum gain");

  ////////////////////////////////////////////////////////////////////////
  // checks: host port and power register

  a_flag_port: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst && !$past(sys_rst) && req.rd && req.addr == `APS_OFS_FLAGS
    |=> rdata == $past(flagsNow, 2))
    else $error("flag read does not match the record path");

  a_read_valid: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst && req.rd
    |=> rdValid)
    else $error("read strobe not answered");

  a_valid_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst && !req.rd
    |=> !rdValid)
    else $error("read valid without a read strobe");

  a_rdata_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst && !req.rd
    |=> $stable(rdata))
    else $error("read data changed without a read");

  a_pwr_read: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst && req.rd && req.addr == `APS_OFS_PWR
    |=> rdValid && rdata == $past(state_reg.pwr))
    else $error("power register read returns wrong data");

  a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst
    |=> (state_reg.pwr & ~(`APS_PWR_RW_MASK)) == 8'h00)
    else $error("reserved power bits not zero");

  a_dac_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst && !req.wr
    |=> $stable(leftDacPowerUp) && $stable(rightDacPowerUp))
    else $error("dac power changed without a write");

  a_reset_outputs: assert property (@(posedge clk)
    sys_rst
    |=> !rdValid && rdata == 8'h00 && !leftDacPowerUp && !rightDacPowerUp && hpComMode == 2'h0)
    else $error("outputs not cleared by reset");

endmodule

// File: inc/aps_consts.svh
// offsets, field positions and reset values of the flag and power registers
`ifndef APS_CONSTS_SVH
`define APS_CONSTS_SVH

`define APS_GAIN_W 8
`define APS_OFS_FLAGS 8'h24
`define APS_OFS_PWR 8'h25
`define APS_FLAGS_RST 8'h00
`define APS_PWR_RST 8'h00

`define APS_BIT_L_SETTLED 7
`define APS_BIT_L_ADC_ON 6
`define APS_BIT_L_QUIET 5
`define APS_BIT_L_SAT 4
`define APS_BIT_R_SETTLED 3
`define APS_BIT_R_ADC_ON 2
`define APS_BIT_R_QUIET 1
`define APS_BIT_R_SAT 0

`define APS_BIT_L_DAC 7
`define APS_BIT_R_DAC 6
`define APS_HPCOM_HI 5
`define APS_HPCOM_LO 4
`define APS_PWR_RW_MASK 8'hF0

`endif

// File: inc/aps_pkg.sv
// types shared by the flag and power register block
`include "aps_consts.svh"

package aps_pkg;

  typedef logic [`APS_GAIN_W-1:0] aps_gain_t;

  // per-channel record path state seen by the flag register
  typedef struct packed {
    aps_gain_t appliedGain;
    aps_gain_t programmedGain;
    aps_gain_t maxGain;
    logic adcPowered;
    logic belowNoise;
  } aps_chan_s;

  // host register access
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } aps_req_s;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] pwr;
    logic [7:0] rdata;
    logic rdValid;
  } aps_state_s;

endpackage

// File: bench/aps_regs_test.sv
// self-checking bench for the flag and power register block
`timescale 1ns/1ps
`include "aps_consts.svh"

module aps_regs_test;
  import aps_pkg::*;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  aps_chan_s chL = '0;
  aps_chan_s chR = '0;
  aps_req_s req = '0;
  logic [7:0] rdata;
  logic rdValid;
  logic lDac;
  logic rDac;
  logic [1:0] hpMode;
  logic [7:0] expQ[$];
  logic [7:0] wv;
  int error_cnt = 0;
  int check_count = 0;

  always #12.5 clk = ~clk;

  aps_regs dut (.clk(clk), .sys_rst(sysRst), .chanLeft(chL), .chanRight(chR), .req(req),
    .rdata(rdata), .rdValid(rdValid), .leftDacPowerUp(lDac), .rightDacPowerUp(rDac),
    .hpComMode(hpMode));

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic complete_run();
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // one-cycle strobe, released at the following edge
  task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wr: w, rd: !w, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    access(a, 1'b0, 8'h00);
  endtask

  function automatic logic [7:0] flagsOf(input aps_chan_s l, input aps_chan_s r);
    return {l.appliedGain == l.programmedGain, l.adcPowered, l.belowNoise,
            l.appliedGain == l.maxGain, r.appliedGain == r.programmedGain, r.adcPowered,
            r.belowNoise, r.appliedGain == r.maxGain};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (rdValid === 1'b1) begin
      check("read data", rdata, expQ.size() > 0 ? expQ.pop_front() : 8'hXX);
    end
  end

  initial begin
    #50000;
    error_cnt++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h8D07));
    repeat (4) @(posedge clk);
    sysRst <= 1'b0;
    rd(`APS_OFS_PWR, `APS_PWR_RST);
    for (int i = 0; i < 20; i++) begin
      // small gain range so equal gains come up often
      @(posedge clk);
      chL <= aps_chan_s'(26'($urandom) & 26'h00C0C0F);
      chR <= aps_chan_s'(26'($urandom) & 26'h00C0C0F);
      access(`APS_OFS_FLAGS, 1'b1, 8'($urandom));
      rd(`APS_OFS_FLAGS, flagsOf(chL, chR));
      wv = 8'($urandom);
      access(`APS_OFS_PWR, 1'b1, wv);
      rd(`APS_OFS_PWR, wv & `APS_PWR_RW_MASK);
      check("dac power", {lDac, rDac, hpMode, 4'h0}, wv & `APS_PWR_RW_MASK);
      rd(8'h26, 8'h00);
    end
    @(posedge clk);
    sysRst <= 1'b1;
    @(posedge clk);
    sysRst <= 1'b0;
    rd(`APS_OFS_PWR, `APS_PWR_RST);
    check("dac power", {lDac, rDac, hpMode, 4'h0}, `APS_PWR_RST);
    repeat (3) @(posedge clk);
    check("pending reads", 8'(expQ.size()), 8'h00);
    complete_run();
  end
endmodule
